/* design/ltr_pkg.sv */
// Constants for the temperature value registers and the diagnostic converter.
// Assumes an upstream serial-bus engine that turns bus frames into register strobes.
package ltr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] ADDR_STATUS      = 8'h3A;
	localparam logic [7:0] ADDR_INT_TEMP    = 8'h3F;
	localparam logic [7:0] ADDR_EXT_TEMP    = 8'h40;
	localparam logic [7:0] ADDR_DIAG_CTRL   = 8'h41;
	localparam logic [7:0] ADDR_DIAG_RESULT = 8'h42;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RST_INT_TEMP    = 8'h19;
	localparam logic [7:0] RST_EXT_TEMP    = 8'h00;
	localparam logic [7:0] RST_DIAG_CTRL   = 8'h00;
	localparam logic [7:0] RST_DIAG_RESULT = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Diagnostic control fields
	localparam int BIT_FIRE    = 7;
	localparam int BIT_IRQ_EN  = 6;
	localparam int BIT_REPEAT  = 5;
	localparam int SEL_MSB     = 4;
	localparam int SEL_W       = 5;

	// Input select codes
	localparam logic [4:0] SEL_LED_FIRST = 5'h00;
	localparam logic [4:0] SEL_LED_LAST  = 5'h08;
	localparam logic [4:0] SEL_PUMP      = 5'h0F;
	localparam logic [4:0] SEL_BATTERY   = 5'h10;
	localparam logic [4:0] SEL_INT_PIN   = 5'h11;
	localparam int         N_LED         = 9;
	localparam int         N_ROUTE       = 12;
	localparam int         ROUTE_PUMP    = 9;
	localparam int         ROUTE_BATTERY = 10;
	localparam int         ROUTE_INT_PIN = 11;

	////////////////////////////////////////////////////////////////////////////////
	// Compensation range limits, two's complement degrees
	localparam logic [7:0] TEMP_MAX = 8'h59;
	localparam logic [7:0] TEMP_MIN = 8'hDA;

	////////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS     = 40;
	localparam int DIAG_CONV_TIME_NS = 2700000;
	// Least time: round up
	localparam int DIAG_CONV_CYCLES  =
		(DIAG_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////////////
	// Converter sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MEAS = 2'b01,
		ST_DONE = 2'b10
	} ltr_state_t;

endpackage : ltr_pkg

/* design/ltr_conv_timer.sv */
// Measurement-period timer for the diagnostic converter.
// Assumes i_start is a one-cycle pulse from the sequencer in the same clock domain.
`timescale 1ns/1ps
module ltr_conv_timer #(
	parameter int P_CYCLES = 67500
) (
	input  wire logic i_clk_sys,
	input  wire logic i_resetn,
	input  wire logic i_start,
	output logic      o_busy,
	output logic      o_done
);

	localparam int         CW      = $clog2(P_CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(P_CYCLES);
	localparam logic [CW-1:0] ONE  = CW'(1);
	localparam logic [CW-1:0] ZERO = CW'(0);

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic          done_ff;
	logic          nxt_done;

	////////////////////////////////////////////////////////////////////////////////
	// Count down from the full period; done fires in the first cycle after busy ends
	assign nxt_cnt  = i_start ? LOAD : ((cnt_ff != ZERO) ? cnt_ff - ONE : ZERO);
	assign nxt_done = !i_start && (cnt_ff == ONE);

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			cnt_ff  <= ZERO;
			done_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign o_busy = (cnt_ff != ZERO);
	assign o_done = done_ff;

endmodule : ltr_conv_timer

/* design/ltr_regs.sv */
// Temperature value registers and diagnostic voltage converter control.
// Assumes the serial-bus engine delivers one-cycle read/write strobes with address and data,
// and that the analog converter output is stable when the measurement period ends.
//
// Overview of operation
// [R1]: Internal sensor temperature is read-only signed 8-bit, reset to 25 degrees.
// [R2]: Written temperatures above 89 clamp to 89, below -38 clamp to -38.
// [R3]: Host-writable signed external temperature register, reset to zero.
// [R4]: Each write of one to fire bit starts one diagnostic conversion; fire writes made while one is already pending queue only one more.
// [R5]: Every diagnostic conversion lasts a 2.7 ms measurement period.
// [R6]: Completion interrupt raised only when its enable bit is one.
// [R7]: Reading the status and interrupt register clears the completion interrupt.
// [R8]: Repeat bit runs conversions back to back while fire bit is one.
// [R9]: Repeated conversion halts while the device is in power-save mode; the code stays idle after it ends until a new fire write.
// [R10]: Select codes zero to eight route LED outputs one to nine.
// [R11]: Codes 0F, 10, 11 route pump output, battery, interrupt pin.
// [R12]: Host must not program reserved select codes.
// [R13]: Source select picks internal or external reading for compensation.
// [R14]: Each finished conversion stores its 8-bit result, 30 mV per step.
// [R15]: Reserved select code routes nothing; result undefined, nothing else affected.
`timescale 1ns/1ps
module ltr_regs #(
	parameter int P_CONV_CYCLES = ltr_pkg::DIAG_CONV_CYCLES
) (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_resetn,
	// Register strobes from the serial-bus engine
	input  wire logic [7:0]                 i_reg_addr,
	input  wire logic [7:0]                 i_reg_wdata,
	input  wire logic                       i_reg_wr,
	input  wire logic                       i_reg_rd,
	output logic      [7:0]                 o_reg_rdata,
	output logic                            o_reg_hit,
	// Internal temperature sensor
	input  wire logic [7:0]                 i_sensor_temp,
	input  wire logic                       i_sensor_valid,
	// Compensation source
	input  wire logic                       i_comp_source_select,
	output logic      [7:0]                 o_comp_temp,
	// Device mode
	input  wire logic                       i_power_save,
	// Diagnostic converter analog side
	output logic      [ltr_pkg::N_ROUTE-1:0] o_diag_route,
	output logic                            o_diag_conv_start,
	output logic                            o_diag_busy,
	input  wire logic [7:0]                 i_diag_adc_data,
	// Interrupt request toward the shared interrupt pin logic
	output logic                            o_diag_irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Clamp to compensation range
	function automatic logic [7:0] clamp_temp(input logic [7:0] v);
		if ($signed(v) > $signed(ltr_pkg::TEMP_MAX)) begin
			clamp_temp = ltr_pkg::TEMP_MAX; // [R2]
		end else if ($signed(v) < $signed(ltr_pkg::TEMP_MIN)) begin
			clamp_temp = ltr_pkg::TEMP_MIN; // [R2]
		end else begin
			clamp_temp = v;
		end
	endfunction : clamp_temp

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0]           int_temp_ff;
	logic [7:0]           nxt_int_temp;
	logic [7:0]           ext_temp_ff;
	logic [7:0]           nxt_ext_temp;
	logic [7:0]           ctrl_ff;
	logic [7:0]           nxt_ctrl;
	logic [7:0]           result_ff;
	logic [7:0]           nxt_result;
	logic                 irq_ff;
	logic                 nxt_irq;
	logic                 pend_ff;
	logic                 nxt_pend;
	logic [7:0]           rdata_ff;
	logic [7:0]           nxt_rdata;
	ltr_pkg::ltr_state_t  state_ff;
	ltr_pkg::ltr_state_t  nxt_state;

	logic                 wr_ext;
	logic                 wr_ctrl;
	logic                 rd_status;
	logic                 hit;
	logic                 fire_wr;
	logic                 fire_bit;
	logic                 irq_en;
	logic                 repeat_conversion;
	logic [4:0]           diag_input_select;
	logic                 repeat_go;
	logic                 start_conv;
	logic                 timer_busy;
	logic                 timer_done;
	logic                 done_evt;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode
	assign wr_ext    = i_reg_wr && (i_reg_addr == ltr_pkg::ADDR_EXT_TEMP);
	assign wr_ctrl   = i_reg_wr && (i_reg_addr == ltr_pkg::ADDR_DIAG_CTRL);
	assign rd_status = i_reg_rd && (i_reg_addr == ltr_pkg::ADDR_STATUS);
	assign hit       = (i_reg_addr == ltr_pkg::ADDR_INT_TEMP)
	                || (i_reg_addr == ltr_pkg::ADDR_EXT_TEMP)
	                || (i_reg_addr == ltr_pkg::ADDR_DIAG_CTRL)
	                || (i_reg_addr == ltr_pkg::ADDR_DIAG_RESULT);
	assign o_reg_hit = hit;

	// Control fields
	assign fire_bit          = ctrl_ff[ltr_pkg::BIT_FIRE];
	assign irq_en            = ctrl_ff[ltr_pkg::BIT_IRQ_EN];
	assign repeat_conversion = ctrl_ff[ltr_pkg::BIT_REPEAT];
	assign diag_input_select = ctrl_ff[ltr_pkg::SEL_MSB:0];
	assign fire_wr           = wr_ctrl && i_reg_wdata[ltr_pkg::BIT_FIRE]; // [R4]

	////////////////////////////////////////////////////////////////////////////////
	// Temperature registers
	// Sensor only writes this register; bus writes to it are ignored
	assign nxt_int_temp = i_sensor_valid ? clamp_temp(i_sensor_temp) : int_temp_ff; // [R1]
	assign nxt_ext_temp = wr_ext ? clamp_temp(i_reg_wdata) : ext_temp_ff; // [R3] [R2]
	assign o_comp_temp  = i_comp_source_select ? ext_temp_ff : int_temp_ff; // [R13]

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			int_temp_ff <= ltr_pkg::RST_INT_TEMP; // [R1]
			ext_temp_ff <= ltr_pkg::RST_EXT_TEMP; // [R3]
		end else begin
			int_temp_ff <= nxt_int_temp;
			ext_temp_ff <= nxt_ext_temp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register
	assign nxt_ctrl = wr_ctrl ? i_reg_wdata : ctrl_ff;

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			ctrl_ff <= ltr_pkg::RST_DIAG_CTRL;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input routing, one-hot or all zero toward the analog mux
	genvar g;
	generate
		for (g = 0; g < ltr_pkg::N_LED; g++) begin : g_led_route
			assign o_diag_route[g] = (diag_input_select == (ltr_pkg::SEL_LED_FIRST
			                          + 5'(g))); // [R10]
		end
	endgenerate
	// Reserved codes leave every route off [R15] [R12]
	assign o_diag_route[ltr_pkg::ROUTE_PUMP]    = (diag_input_select == ltr_pkg::SEL_PUMP); // [R11]
	assign o_diag_route[ltr_pkg::ROUTE_BATTERY] =
		(diag_input_select == ltr_pkg::SEL_BATTERY); // [R11]
	assign o_diag_route[ltr_pkg::ROUTE_INT_PIN] =
		(diag_input_select == ltr_pkg::SEL_INT_PIN); // [R11]

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer
	// A fire write during a measurement is queued, not dropped
	assign repeat_go  = fire_bit && repeat_conversion && !i_power_save; // [R8] [R9]
	assign done_evt   = (state_ff == ltr_pkg::ST_MEAS) && timer_done;

	always_comb begin
		nxt_state  = state_ff;
		start_conv = 1'b0;
		case (state_ff)
			ltr_pkg::ST_IDLE: begin
				if (fire_wr || pend_ff) begin
					start_conv = 1'b1; // [R4]
					nxt_state  = ltr_pkg::ST_MEAS;
				end
			end
			ltr_pkg::ST_MEAS: begin
				if (timer_done) begin
					nxt_state = ltr_pkg::ST_DONE; // [R5]
				end
			end
			ltr_pkg::ST_DONE: begin
				if (repeat_go || fire_wr || pend_ff) begin
					start_conv = 1'b1; // [R8]
					nxt_state  = ltr_pkg::ST_MEAS;
				end else begin
					nxt_state = ltr_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = ltr_pkg::ST_IDLE;
			end
		endcase
	end

	assign nxt_pend = start_conv ? 1'b0 : (pend_ff || fire_wr); // [R4]

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			state_ff <= ltr_pkg::ST_IDLE;
			pend_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pend_ff  <= nxt_pend;
		end
	end

	ltr_conv_timer #(
		.P_CYCLES (P_CONV_CYCLES)
	) u_timer (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_start   (start_conv), // [R5]
		.o_busy    (timer_busy),
		.o_done    (timer_done)
	);

	assign o_diag_conv_start = start_conv;
	assign o_diag_busy       = timer_busy;

	////////////////////////////////////////////////////////////////////////////////
	// Result capture at the end of the period
	assign nxt_result = done_evt ? i_diag_adc_data : result_ff; // [R14]

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			result_ff <= ltr_pkg::RST_DIAG_RESULT;
		end else begin
			result_ff <= nxt_result;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Completion interrupt; a new completion wins over a same-cycle clear
	assign nxt_irq = (done_evt && irq_en) ? 1'b1 : (rd_status ? 1'b0 : irq_ff); // [R6] [R7]

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	assign o_diag_irq = irq_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the read strobe; unmapped reads give zero
	always_comb begin
		nxt_rdata = rdata_ff;
		if (i_reg_rd) begin
			case (i_reg_addr)
				ltr_pkg::ADDR_INT_TEMP:    nxt_rdata = int_temp_ff; // [R1]
				ltr_pkg::ADDR_EXT_TEMP:    nxt_rdata = ext_temp_ff; // [R3]
				ltr_pkg::ADDR_DIAG_CTRL:   nxt_rdata = ctrl_ff;
				ltr_pkg::ADDR_DIAG_RESULT: nxt_rdata = result_ff; // [R14]
				default:                   nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_reg_rdata = rdata_ff;

endmodule : ltr_regs

/* sim/ltr_adc_model.sv */
// Behavioural analog converter standing behind the diagnostic input routing.
// Assumes the route vector is one-hot or all zero.
`timescale 1ns/1ps
module ltr_adc_model (
	input  wire logic [ltr_pkg::N_ROUTE-1:0] i_route,
	output logic      [7:0]                  o_adc_data
);
	// One distinct code per route, so a wrong route shows in the result
	always_comb begin
		o_adc_data = 8'hA5;
		for (int k = 0; k < ltr_pkg::N_ROUTE; k++) begin
			if (i_route[k]) o_adc_data = 8'h30 + 8'(k);
		end
	end
endmodule : ltr_adc_model

/* sim/ltr_regs_properties.sv */
// Port-level checker for the temperature and diagnostic register block.
// Assumes it is bound to ltr_regs and sees only that module's ports.
`timescale 1ns/1ps
module ltr_regs_properties #(
	parameter int P_CONV_CYCLES = 5
) (
	input wire logic                        i_clk_sys,
	input wire logic                        i_resetn,
	input wire logic [7:0]                  i_reg_addr,
	input wire logic                        i_reg_rd,
	input wire logic [7:0]                  o_reg_rdata,
	input wire logic [7:0]                  i_sensor_temp,
	input wire logic                        i_sensor_valid,
	input wire logic                        i_comp_source_select,
	input wire logic [7:0]                  o_comp_temp,
	input wire logic [ltr_pkg::N_ROUTE-1:0] o_diag_route,
	input wire logic                        o_diag_conv_start,
	input wire logic                        o_diag_busy,
	input wire logic                        o_diag_irq
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	////////////////////////////////////////////////////////////////////////////////
	// Busy length counter; repetition cannot count this far
	logic [15:0] busy_cnt_ff;
	logic [15:0] nxt_busy_cnt;
	assign nxt_busy_cnt = o_diag_busy ? busy_cnt_ff + 16'h0001 : 16'h0000;
	always_ff @(posedge i_clk_sys) begin
		busy_cnt_ff <= i_resetn ? nxt_busy_cnt : 16'h0000;
	end

	sequence meas_s;
		!o_diag_busy ##1 o_diag_busy;
	endsequence
	sequence sense_hi_s;
		i_sensor_valid && !i_comp_source_select && !i_sensor_temp[7]
			&& i_sensor_temp > ltr_pkg::TEMP_MAX ##1 !i_comp_source_select;
	endsequence
	sequence sense_lo_s;
		i_sensor_valid && !i_comp_source_select && i_sensor_temp[7]
			&& i_sensor_temp < ltr_pkg::TEMP_MIN ##1 !i_comp_source_select;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	start_busy_a: assert property (o_diag_conv_start |-> meas_s)
		else $error("busy did not follow conversion start");
	busy_len_a: assert property ($fell(o_diag_busy) |-> busy_cnt_ff == P_CONV_CYCLES)
		else $error("measurement period length wrong");
	irq_set_a: assert property ($rose(o_diag_irq) |-> $past(o_diag_busy, 2) && !$past(o_diag_busy))
		else $error("interrupt rose outside conversion end");
	irq_clear_a: assert property (i_reg_rd && i_reg_addr == ltr_pkg::ADDR_STATUS
		&& !$fell(o_diag_busy) |=> !o_diag_irq)
		else $error("status read did not clear interrupt");
	route_one_a: assert property ($onehot0(o_diag_route))
		else $error("more than one route selected");
	clamp_high_a: assert property (sense_hi_s |-> o_comp_temp == ltr_pkg::TEMP_MAX)
		else $error("high sensor value not clamped");
	clamp_low_a: assert property (sense_lo_s |-> o_comp_temp == ltr_pkg::TEMP_MIN)
		else $error("low sensor value not clamped");
	int_hold_a: assert property (!i_sensor_valid && !i_comp_source_select ##1
		!i_comp_source_select |-> $stable(o_comp_temp))
		else $error("internal temperature changed without sensor update");
	rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data changed without read");
endmodule : ltr_regs_properties

bind ltr_regs ltr_regs_properties #(.P_CONV_CYCLES(P_CONV_CYCLES)) chk_u (
	.i_clk_sys, .i_resetn, .i_reg_addr, .i_reg_rd, .o_reg_rdata, .i_sensor_temp,
	.i_sensor_valid, .i_comp_source_select, .o_comp_temp, .o_diag_route,
	.o_diag_conv_start, .o_diag_busy, .o_diag_irq
);

/* sim/tb.sv */
// Self-checking bench for the temperature and diagnostic register block.
// Assumes register strobes as the serial-bus engine gives them.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb;
	localparam int P = 5;
	logic       i_clk_sys, i_resetn, i_reg_wr, i_reg_rd, o_reg_hit;
	logic       i_sensor_valid, i_comp_source_select, i_power_save;
	logic       o_diag_conv_start, o_diag_busy, o_diag_irq;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_sensor_temp, o_comp_temp;
	logic [7:0] i_diag_adc_data;
	logic [ltr_pkg::N_ROUTE-1:0] o_diag_route;
	int         error_cnt, total_checks;

	ltr_regs #(.P_CONV_CYCLES(P)) dut_u (.i_clk_sys, .i_resetn, .i_reg_addr, .i_reg_wdata,
		.i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_hit, .i_sensor_temp, .i_sensor_valid,
		.i_comp_source_select, .o_comp_temp, .i_power_save, .o_diag_route,
		.o_diag_conv_start, .o_diag_busy, .i_diag_adc_data, .o_diag_irq);
	ltr_adc_model adc_u (.i_route(o_diag_route), .o_adc_data(i_diag_adc_data));

	////////////////////////////////////////////////////////////////////////////////
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		#1;
		`CHK(o_reg_rdata, e)
	endtask : rd_chk

	// Bounded wait for a measurement, returns its busy length
	task automatic conv_wait(output int n);
		int t;
		n = 0;
		t = 0;
		// Step past the launching edge so busy is never read mid-update
		#1;
		while (!o_diag_busy && t < 20) begin
			@(posedge i_clk_sys);
			#1;
			t++;
		end
		while (o_diag_busy && n < 4 * P) begin
			n++;
			@(posedge i_clk_sys);
			#1;
		end
	endtask : conv_wait

	task automatic t_temp;
		logic [7:0] w[7] = '{8'h5A, 8'h7F, 8'h59, 8'hD9, 8'h80, 8'hDA, 8'hE0};
		logic [7:0] e[7] = '{8'h59, 8'h59, 8'h59, 8'hDA, 8'hDA, 8'hDA, 8'hE0};
		logic [7:0] s[3] = '{8'h7F, 8'h90, 8'h20};
		logic [7:0] x[3] = '{8'h59, 8'hDA, 8'h20};
		rd_chk(ltr_pkg::ADDR_INT_TEMP, 8'h19);
		rd_chk(ltr_pkg::ADDR_EXT_TEMP, 8'h00);
		wr_reg(ltr_pkg::ADDR_INT_TEMP, 8'h05);
		rd_chk(ltr_pkg::ADDR_INT_TEMP, 8'h19);
		for (int k = 0; k < 7; k++) begin
			wr_reg(ltr_pkg::ADDR_EXT_TEMP, w[k]);
			rd_chk(ltr_pkg::ADDR_EXT_TEMP, e[k]);
		end
		`CHK(o_reg_hit, 1'b1)
		for (int k = 0; k < 3; k++) begin
			@(posedge i_clk_sys);
			i_sensor_temp <= s[k];
			i_sensor_valid <= 1'b1;
			@(posedge i_clk_sys);
			i_sensor_valid <= 1'b0;
			rd_chk(ltr_pkg::ADDR_INT_TEMP, x[k]);
		end
		`CHK(o_comp_temp, 8'h20)
		@(posedge i_clk_sys);
		i_comp_source_select <= 1'b1;
		@(posedge i_clk_sys);
		`CHK(o_comp_temp, 8'hE0)
		i_comp_source_select <= 1'b0;
	endtask : t_temp

	task automatic t_route;
		for (int k = 0; k < ltr_pkg::N_ROUTE; k++) begin
			wr_reg(ltr_pkg::ADDR_DIAG_CTRL, (k < 9) ? 8'(k) : 8'(k + 6));
			#1;
			`CHK(o_diag_route, 12'h001 << k)
		end
		wr_reg(ltr_pkg::ADDR_DIAG_CTRL, 8'h0A);
		#1;
		`CHK(o_diag_route, 12'h000)
	endtask : t_route

	task automatic t_conv;
		int n;
		wr_reg(ltr_pkg::ADDR_DIAG_CTRL, {3'b110, ltr_pkg::SEL_PUMP});
		conv_wait(n);
		`CHK(n, P)
		@(posedge i_clk_sys);
		#1;
		`CHK(o_diag_irq, 1'b1)
		rd_chk(ltr_pkg::ADDR_DIAG_RESULT, 8'h39);
		rd_chk(ltr_pkg::ADDR_STATUS, 8'h00);
		`CHK(o_diag_irq, 1'b0)
		`CHK(o_reg_hit, 1'b0)
		conv_wait(n);
		`CHK(n, 0)
		wr_reg(ltr_pkg::ADDR_DIAG_CTRL, 8'h80);
		conv_wait(n);
		repeat (3) @(posedge i_clk_sys);
		`CHK(o_diag_irq, 1'b0)
		rd_chk(ltr_pkg::ADDR_DIAG_RESULT, 8'h30);
	endtask : t_conv

	task automatic t_repeat;
		int n;
		wr_reg(ltr_pkg::ADDR_DIAG_CTRL, {3'b101, ltr_pkg::SEL_BATTERY});
		conv_wait(n);
		conv_wait(n);
		`CHK(n, P)
		rd_chk(ltr_pkg::ADDR_DIAG_RESULT, 8'h3A);
		@(posedge i_clk_sys);
		i_power_save <= 1'b1;
		repeat (2 * P + 6) @(posedge i_clk_sys);
		conv_wait(n);
		`CHK(n, 0)
		@(posedge i_clk_sys);
		i_power_save <= 1'b0;
		wr_reg(ltr_pkg::ADDR_DIAG_CTRL, 8'h00);
		conv_wait(n);
	endtask : t_repeat

	task automatic end_of_test;
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end

	initial begin
		{i_reg_wr, i_reg_rd, i_sensor_valid, i_comp_source_select, i_power_save} = 5'h00;
		{i_reg_addr, i_reg_wdata, i_sensor_temp} = 24'h000000;
		i_resetn = 1'b0;
		error_cnt = 0;
		total_checks = 0;
		repeat (4) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		rd_chk(ltr_pkg::ADDR_DIAG_CTRL, 8'h00);
		t_temp();
		t_route();
		t_conv();
		t_repeat();
		end_of_test();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#(40 * 5000);
		error_cnt++;
		end_of_test();
	end
endmodule : tb
